// ===== hw/epir_regs.sv
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// RQ1 - Pull-up disable bit overrides all port latches
// RQ2 - Edge select bits pick rising or falling
// RQ3 - Timer0, ext3, port change priority bits
// RQ4 - Ext2 and ext1 priority bits
// RQ5 - Ext3, ext2, ext1 enable bits
// RQ6 - Ext flags set on edge, software clears
// RQ7 - Flags set regardless of any enable
// RQ8 - Software clears flags around enabling, servicing
// RQ9 - Parallel slave transfer sets sticky flag
// RQ10 - Conversion done sets sticky flag
// RQ11 - Receive full flag mirrors buffer, read-only
// RQ12 - Transmit empty flag mirrors buffer, read-only
// RQ13 - Sync port transfer done sets flag
// RQ14 - Capture/compare events set flags, not PWM
// RQ15 - Timer2 period match sets sticky flag
// RQ16 - Timer1 overflow sets sticky flag
// RQ17 - Oscillator failure sets sticky flag
// RQ18 - Comparator change sets sticky flag
// RQ19 - Unimplemented request bits read zero
// RQ20 - Bus collision sets sticky flag
// RQ21 - Timer3 overflow sets sticky flag
// RQ22 - Enabled request vectors by priority address
// RQ23 - Priority bits ignored when feature off
// RQ24 - Peripherals need peripheral enable when compatible
// RQ25 - Writing zero clears; event wins
module epir_regs (
    input wire logic clock,
    input wire logic rst,
    input wire logic wb_cyc,
    input wire logic wb_stb,
    input wire logic wb_we,
    input wire logic [7:0] wb_adr,
    input wire logic [3:0] wb_sel,
    input wire logic [31:0] wb_dat_wr,
    output logic [31:0] wb_dat_rd,
    output logic wb_ack,
    input wire logic [3:0] ext_pin,
    input wire logic [7:0] portb_latch,
    output logic [7:0] portb_pullup_on,
    output logic ext0_event,
    input wire logic par_slave_done,
    input wire logic conv_done,
    input wire logic rx_buffer_full,
    input wire logic tx_buffer_empty,
    input wire logic sync_port1_done,
    input wire logic capcmp1_event,
    input wire logic capcmp2_event,
    input wire logic [1:0] capcmp_pwm_mode,
    input wire logic timer2_match,
    input wire logic timer1_ovf,
    input wire logic osc_fail,
    input wire logic comparator_change,
    input wire logic bus_collision1,
    input wire logic timer3_ovf,
    input wire logic timer0_req,
    input wire logic port_change_req,
    output logic irq_request,
    output logic irq_high,
    output logic [15:0] irq_vector
);

    logic [7:0] int_control_two, int_control_three, periph_request_one, periph_request_two;
    logic [7:0] core_ctrl, periph_en_one, periph_en_two, periph_prio_one, periph_prio_two;
    logic [3:0] ext_event;
    logic bus_req;
    logic wr_req;
    logic [7:0] wbyte;
    logic wr_ctl_two, wr_ctl_three, wr_req_one, wr_req_two, wr_core;
    logic wr_en_one, wr_en_two, wr_prio_one, wr_prio_two;
    logic [7:0] next_rd;
    logic [7:0] set_one;
    logic [7:0] set_two;
    logic [2:0] ext_req;
    logic [2:0] ext_prio;
    logic [7:0] per_req_one;
    logic [7:0] per_req_two;
    logic any_core, any_per, high_hit, low_hit;
    logic next_request, next_high;

    // External pin synchronisers, one per pin
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_ext
            epir_edge_sync u_sync (
                .clock(clock),
                .rst(rst),
                .pin(ext_pin[gi]),
                .rising_sel(int_control_two[epir_pkg::POS_EDGE_SEL_0 - gi]), // RQ2
                .event_pulse(ext_event[gi])
            );
        end
    endgenerate

    // Bus decode, writes act in the cycle before the ack
    assign bus_req = wb_cyc & wb_stb & ~wb_ack;
    assign wr_req = bus_req & wb_we & wb_sel[0];
    assign wbyte = wb_dat_wr[7:0];
    always_comb begin
        wr_ctl_two = 1'b0;
        wr_ctl_three = 1'b0;
        wr_req_one = 1'b0;
        wr_req_two = 1'b0;
        wr_core = 1'b0;
        wr_en_one = 1'b0;
        wr_en_two = 1'b0;
        wr_prio_one = 1'b0;
        wr_prio_two = 1'b0;
        if (wb_adr == epir_pkg::OFF_INT_CONTROL_TWO) begin
            wr_ctl_two = wr_req;
        end else if (wb_adr == epir_pkg::OFF_INT_CONTROL_THREE) begin
            wr_ctl_three = wr_req;
        end else if (wb_adr == epir_pkg::OFF_PERIPH_REQUEST_ONE) begin
            wr_req_one = wr_req;
        end else if (wb_adr == epir_pkg::OFF_PERIPH_REQUEST_TWO) begin
            wr_req_two = wr_req;
        end else if (wb_adr == epir_pkg::OFF_CORE_CTRL) begin
            wr_core = wr_req;
        end else if (wb_adr == epir_pkg::OFF_PERIPH_EN_ONE) begin
            wr_en_one = wr_req;
        end else if (wb_adr == epir_pkg::OFF_PERIPH_EN_TWO) begin
            wr_en_two = wr_req;
        end else if (wb_adr == epir_pkg::OFF_PERIPH_PRIO_ONE) begin
            wr_prio_one = wr_req;
        end else if (wb_adr == epir_pkg::OFF_PERIPH_PRIO_TWO) begin
            wr_prio_two = wr_req;
        end
    end

    // Read mux, unmapped addresses read zero
    always_comb begin
        next_rd = 8'h00;
        if (wb_adr == epir_pkg::OFF_INT_CONTROL_TWO) begin
            next_rd = int_control_two;
        end else if (wb_adr == epir_pkg::OFF_INT_CONTROL_THREE) begin
            next_rd = int_control_three;
        end else if (wb_adr == epir_pkg::OFF_PERIPH_REQUEST_ONE) begin
            next_rd = periph_request_one;
        end else if (wb_adr == epir_pkg::OFF_PERIPH_REQUEST_TWO) begin
            next_rd = periph_request_two & epir_pkg::MASK_REQUEST_TWO; // RQ19
        end else if (wb_adr == epir_pkg::OFF_CORE_CTRL) begin
            next_rd = core_ctrl;
        end else if (wb_adr == epir_pkg::OFF_PERIPH_EN_ONE) begin
            next_rd = periph_en_one;
        end else if (wb_adr == epir_pkg::OFF_PERIPH_EN_TWO) begin
            next_rd = periph_en_two;
        end else if (wb_adr == epir_pkg::OFF_PERIPH_PRIO_ONE) begin
            next_rd = periph_prio_one;
        end else if (wb_adr == epir_pkg::OFF_PERIPH_PRIO_TWO) begin
            next_rd = periph_prio_two;
        end
    end

    // Single-cycle ack with registered read data
    always_ff @(posedge clock) begin
        if (rst) begin
            wb_ack <= 1'b0;
            wb_dat_rd <= 32'h00000000;
        end else begin
            wb_ack <= bus_req;
            wb_dat_rd <= bus_req ? {24'h000000, next_rd} : 32'h00000000;
        end
    end

    // Second control register: pull-up, edges, priorities
    always_ff @(posedge clock) begin
        if (rst) begin
            int_control_two <= epir_pkg::RST_INT_CONTROL_TWO;
        end else if (wr_ctl_two) begin
            int_control_two <= wbyte; // RQ3
        end
    end

    // Third control register: priorities, enables, sticky ext flags
    always_ff @(posedge clock) begin
        if (rst) begin
            int_control_three <= epir_pkg::RST_INT_CONTROL_THREE;
        end else begin
            if (wr_ctl_three) begin
                int_control_three[7:3] <= wbyte[7:3]; // RQ4 RQ5
            end
            // Edge event beats a clearing write
            int_control_three[2:0] <= ext_event[3:1] |
                (wr_ctl_three ? wbyte[2:0] : int_control_three[2:0]); // RQ6 RQ7 RQ25
        end
    end

    // Peripheral event sets, capture/compare ignored in PWM mode
    assign set_one = {par_slave_done, conv_done, 2'b00, sync_port1_done,
        capcmp1_event & ~capcmp_pwm_mode[0], timer2_match, timer1_ovf}; // RQ9 RQ10 RQ13 RQ14 RQ15 RQ16
    assign set_two = {osc_fail, comparator_change, 2'b00, bus_collision1, 1'b0,
        timer3_ovf, capcmp2_event & ~capcmp_pwm_mode[1]}; // RQ14 RQ17 RQ18 RQ20 RQ21

    // First request register, set wins over software clear
    always_ff @(posedge clock) begin
        if (rst) begin
            periph_request_one <= epir_pkg::RST_ZERO;
        end else begin
            periph_request_one <= set_one | (wr_req_one ? wbyte : periph_request_one); // RQ7 RQ25
            periph_request_one[epir_pkg::POS_RX_FULL] <= rx_buffer_full; // RQ11
            periph_request_one[epir_pkg::POS_TX_EMPTY] <= tx_buffer_empty; // RQ12
        end
    end

    // Second request register, unimplemented bits held at zero
    always_ff @(posedge clock) begin
        if (rst) begin
            periph_request_two <= epir_pkg::RST_ZERO;
        end else begin
            periph_request_two <= (set_two | (wr_req_two ? wbyte : periph_request_two))
                & epir_pkg::MASK_REQUEST_TWO; // RQ19 RQ25
        end
    end

    // Global enables, priority feature and peripheral enables
    always_ff @(posedge clock) begin
        if (rst) begin
            core_ctrl <= epir_pkg::RST_ZERO;
            periph_en_one <= epir_pkg::RST_ZERO;
            periph_en_two <= epir_pkg::RST_ZERO;
        end else begin
            if (wr_core) begin
                core_ctrl <= wbyte;
            end
            if (wr_en_one) begin
                periph_en_one <= wbyte;
            end
            if (wr_en_two) begin
                periph_en_two <= wbyte & epir_pkg::MASK_REQUEST_TWO;
            end
        end
    end

    // Peripheral priority bits
    always_ff @(posedge clock) begin
        if (rst) begin
            periph_prio_one <= epir_pkg::RST_ZERO;
            periph_prio_two <= epir_pkg::RST_ZERO;
        end else begin
            if (wr_prio_one) begin
                periph_prio_one <= wbyte;
            end
            if (wr_prio_two) begin
                periph_prio_two <= wbyte & epir_pkg::MASK_REQUEST_TWO;
            end
        end
    end

    // Pull-ups and ext0 edge out to the port logic
    always_ff @(posedge clock) begin
        if (rst) begin
            portb_pullup_on <= 8'h00;
            ext0_event <= 1'b0;
        end else begin
            portb_pullup_on <= int_control_two[epir_pkg::POS_PULLUP_DIS] ? 8'h00
                : portb_latch; // RQ1
            ext0_event <= ext_event[0];
        end
    end

    // Enabled requests and their priorities
    assign ext_req = int_control_three[5:3] & int_control_three[2:0]; // RQ5
    assign ext_prio = {int_control_two[epir_pkg::POS_EXT3_PRIO],
        int_control_three[epir_pkg::POS_EXT2_PRIO],
        int_control_three[epir_pkg::POS_EXT1_PRIO]}; // RQ4
    assign per_req_one = periph_request_one & periph_en_one;
    assign per_req_two = periph_request_two & periph_en_two;
    assign any_core = (|ext_req) | timer0_req | port_change_req;
    assign any_per = (|per_req_one) | (|per_req_two);
    assign high_hit = (|(ext_req & ext_prio))
        | (timer0_req & int_control_two[epir_pkg::POS_TIMER0_PRIO])
        | (port_change_req & int_control_two[epir_pkg::POS_PORT_CHG_PRIO])
        | (|(per_req_one & periph_prio_one)) | (|(per_req_two & periph_prio_two)); // RQ3
    assign low_hit = (|(ext_req & ~ext_prio))
        | (timer0_req & ~int_control_two[epir_pkg::POS_TIMER0_PRIO])
        | (port_change_req & ~int_control_two[epir_pkg::POS_PORT_CHG_PRIO])
        | (|(per_req_one & ~periph_prio_one)) | (|(per_req_two & ~periph_prio_two));

    // Request and level selection for the core
    always_comb begin
        if (core_ctrl[epir_pkg::POS_PRIO_FEATURE_EN]) begin
            next_high = core_ctrl[epir_pkg::POS_GLOBAL_EN] & high_hit;
            next_request = next_high | (core_ctrl[epir_pkg::POS_PERIPH_GLOBAL_EN] & low_hit);
        end else begin
            // Compatibility: one level, priorities have no say
            next_high = core_ctrl[epir_pkg::POS_GLOBAL_EN] & (any_core |
                (core_ctrl[epir_pkg::POS_PERIPH_GLOBAL_EN] & any_per)); // RQ23 RQ24
            next_request = next_high;
        end
    end

    // Registered request and vector address
    always_ff @(posedge clock) begin
        if (rst) begin
            irq_request <= 1'b0;
            irq_high <= 1'b0;
            irq_vector <= epir_pkg::VEC_HIGH;
        end else begin
            irq_request <= next_request;
            irq_high <= next_high;
            irq_vector <= next_high ? epir_pkg::VEC_HIGH : epir_pkg::VEC_LOW; // RQ22
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    a_pullup_follow: // RQ1
    assert property (##1 portb_pullup_on == ($past(int_control_two[7]) ? 8'h00
        : $past(portb_latch)))
        else $error("pull-up output does not follow disable bit and latch");

    a_ext1_flag_set: // RQ6
    assert property (ext_event[1] |=> int_control_three[0] ##1 wb_cyc || wb_ack
        || int_control_three[0])
        else $error("ext1 edge did not set its flag");

    a_event_beats_clear: // RQ25
    assert property (conv_done && wr_req_one && !wbyte[6] |=> periph_request_one[6])
        else $error("conversion event lost to a clearing write");

    a_flag_sticky: // RQ9
    assert property (periph_request_one[7] && !wr_req_one |=> periph_request_one[7])
        else $error("parallel slave flag dropped without a write");

    a_unimpl_zero: // RQ19
    assert property (wb_ack && $past(wb_adr) == 8'h0C |-> wb_dat_rd[5:4] == 2'b00
        && wb_dat_rd[2] == 1'b0)
        else $error("unimplemented request bits read nonzero");

    a_rx_full_mirror: // RQ11
    assert property (##1 periph_request_one[5] == $past(rx_buffer_full))
        else $error("receive full flag does not mirror the buffer");

    a_pwm_no_flag: // RQ14
    assert property (capcmp1_event && capcmp_pwm_mode[0] && !periph_request_one[2]
        && !wr_req_one |=> !periph_request_one[2])
        else $error("capture/compare flag set in PWM mode");

    a_compat_vector: // RQ23
    assert property (!core_ctrl[0] && next_request |=> irq_request
        && irq_vector == 16'h0008)
        else $error("compatibility request not at high vector");

    a_periph_gated: // RQ24
    assert property (!core_ctrl[0] && !core_ctrl[6] && !any_core |=> !irq_request)
        else $error("peripheral request passed without peripheral enable");

    a_low_vector: // RQ22
    assert property (core_ctrl[0] && core_ctrl[6] && low_hit && !(core_ctrl[7] && high_hit)
        |=> irq_request && irq_vector == 16'h0018)
        else $error("low priority request not at low vector");

    a_ack_single:
    assert property (wb_ack |=> !wb_ack)
        else $error("ack held for more than one cycle");

    c_ext_flag: cover property (ext_event[2] ##1 int_control_three[1]);
    c_high_irq: cover property (core_ctrl[0] && irq_request && irq_high);
    c_clear_flag: cover property (periph_request_one[0] ##1 !periph_request_one[0]);

endmodule
`default_nettype wire

// ===== hw/epir_pkg.sv
package epir_pkg;

    // Bus geometry
    localparam int ADR_W = 8;
    localparam int DAT_W = 32;
    localparam int REG_W = 8;

    // Register byte offsets
    localparam logic [7:0] OFF_INT_CONTROL_TWO = 8'h00;
    localparam logic [7:0] OFF_INT_CONTROL_THREE = 8'h04;
    localparam logic [7:0] OFF_PERIPH_REQUEST_ONE = 8'h08;
    localparam logic [7:0] OFF_PERIPH_REQUEST_TWO = 8'h0C;
    localparam logic [7:0] OFF_CORE_CTRL = 8'h10;
    localparam logic [7:0] OFF_PERIPH_EN_ONE = 8'h14;
    localparam logic [7:0] OFF_PERIPH_EN_TWO = 8'h18;
    localparam logic [7:0] OFF_PERIPH_PRIO_ONE = 8'h1C;
    localparam logic [7:0] OFF_PERIPH_PRIO_TWO = 8'h20;

    // Values after reset
    localparam logic [7:0] RST_INT_CONTROL_TWO = 8'hFF;
    localparam logic [7:0] RST_INT_CONTROL_THREE = 8'hC0;
    localparam logic [7:0] RST_ZERO = 8'h00;

    // Field positions, second control register
    localparam int POS_PULLUP_DIS = 7;
    localparam int POS_EDGE_SEL_0 = 6;
    localparam int POS_TIMER0_PRIO = 2;
    localparam int POS_EXT3_PRIO = 1;
    localparam int POS_PORT_CHG_PRIO = 0;

    // Field positions, third control register
    localparam int POS_EXT2_PRIO = 7;
    localparam int POS_EXT1_PRIO = 6;
    localparam int POS_EXT1_EN = 3;
    localparam int POS_EXT1_FLAG = 0;

    // Field positions, first request register
    localparam int POS_RX_FULL = 5;
    localparam int POS_TX_EMPTY = 4;

    // Field positions, core control register
    localparam int POS_GLOBAL_EN = 7;
    localparam int POS_PERIPH_GLOBAL_EN = 6;
    localparam int POS_PRIO_FEATURE_EN = 0;

    // Implemented bits of the second request register
    localparam logic [7:0] MASK_REQUEST_TWO = 8'hCB;

    // Vector addresses
    localparam logic [15:0] VEC_HIGH = 16'h0008;
    localparam logic [15:0] VEC_LOW = 16'h0018;

endpackage

// ===== hw/epir_edge_sync.sv
`timescale 1ns/1ps
`default_nettype none

// Pin synchroniser with selectable edge detection
module epir_edge_sync (
    input wire logic clock,
    input wire logic rst,
    input wire logic pin,
    input wire logic rising_sel,
    output logic event_pulse
);

    logic meta;
    logic stable;
    logic prev;

    // Two-stage synchroniser, first stage read only by the second
    // Runs through reset so a pin idling high gives no false edge
    always_ff @(posedge clock) begin
        meta <= pin;
        stable <= meta;
    end

    // Edge detect on the settled level, polarity chosen by software
    always_ff @(posedge clock) begin
        prev <= stable;
        if (rst) begin
            event_pulse <= 1'b0;
        end else begin
            event_pulse <= rising_sel ? (stable & ~prev) : (~stable & prev);
        end
    end

endmodule
`default_nettype wire

// ===== verif/epir_src_model.sv
`timescale 1ns/1ps
`default_nettype none

// Peripheral event sources: one registered pulse per fire request
module epir_src_model (
    input wire logic clock,
    input wire logic rst,
    input wire logic [10:0] fire,
    output logic [10:0] ev
);
    // Pulses stay quiet through reset
    always_ff @(posedge clock) begin
        if (rst) begin
            ev <= 11'h000;
        end else begin
            ev <= fire;
        end
    end
endmodule

`default_nettype wire

// ===== verif/testbench.sv
`timescale 1ns/1ps
`default_nettype none

module testbench;
    localparam logic [7:0] R2 = epir_pkg::OFF_INT_CONTROL_TWO;
    localparam logic [7:0] R3 = epir_pkg::OFF_INT_CONTROL_THREE;
    localparam logic [7:0] Q1 = epir_pkg::OFF_PERIPH_REQUEST_ONE;
    localparam logic [7:0] Q2 = epir_pkg::OFF_PERIPH_REQUEST_TWO;
    localparam logic [7:0] CORE = epir_pkg::OFF_CORE_CTRL;
    localparam logic [87:0] EV_BITS = 88'h8040080402018040080201;
    logic clock = 1'h0;
    logic rst = 1'h1;
    logic wb_cyc = 1'h0;
    logic wb_stb = 1'h0;
    logic wb_we = 1'h0;
    logic [7:0] wb_adr = 8'h00;
    logic [3:0] wb_sel = 4'hF;
    logic [31:0] wb_dat_wr = 32'h00000000;
    logic [31:0] wb_dat_rd;
    logic wb_ack;
    logic [3:0] ext_pin = 4'h0;
    logic [7:0] portb_latch = 8'h00;
    logic [7:0] portb_pullup_on;
    logic ext0_event;
    logic rx_full = 1'h0;
    logic tx_empty = 1'h0;
    logic [1:0] pwm_mode = 2'h0;
    logic timer0_req = 1'h0;
    logic port_chg_req = 1'h0;
    logic irq_request;
    logic irq_high;
    logic [15:0] irq_vector;
    logic [10:0] fire = 11'h000;
    logic [10:0] ev;
    logic [31:0] seed = 32'h00017675;
    logic [31:0] v;
    int error_cnt = 0;
    int check_count = 0;
    int ev0_cnt = 0;

    // Clock at 5 ns period
    always #2.5 clock = ~clock;

    // Far-side event sources
    epir_src_model src (.clock(clock), .rst(rst), .fire(fire), .ev(ev));

    epir_regs dut (
        .clock(clock), .rst(rst), .wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we),
        .wb_adr(wb_adr), .wb_sel(wb_sel), .wb_dat_wr(wb_dat_wr), .wb_dat_rd(wb_dat_rd),
        .wb_ack(wb_ack), .ext_pin(ext_pin), .portb_latch(portb_latch),
        .portb_pullup_on(portb_pullup_on), .ext0_event(ext0_event),
        .par_slave_done(ev[0]), .conv_done(ev[1]), .rx_buffer_full(rx_full),
        .tx_buffer_empty(tx_empty), .sync_port1_done(ev[2]), .capcmp1_event(ev[3]),
        .capcmp2_event(ev[10]), .capcmp_pwm_mode(pwm_mode), .timer2_match(ev[4]),
        .timer1_ovf(ev[5]), .osc_fail(ev[6]), .comparator_change(ev[7]),
        .bus_collision1(ev[8]), .timer3_ovf(ev[9]), .timer0_req(timer0_req),
        .port_change_req(port_chg_req), .irq_request(irq_request), .irq_high(irq_high),
        .irq_vector(irq_vector)
    );

    // Count edge pulses of external pin 0
    always @(posedge clock) begin
        if (ext0_event === 1'h1) begin
            ev0_cnt++;
        end
    end

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    function automatic logic [7:0] ev_off(input int k);
        return (k < 6) ? Q1 : Q2;
    endfunction

    function automatic logic [7:0] ev_mask(input int k);
        return EV_BITS[87 - 8 * k -: 8];
    endfunction

    // Edge select field order is pin 0 at the top
    function automatic logic [7:0] ctl2_of(input logic pud, input logic [3:0] s);
        return {pud, s[0], s[1], s[2], s[3], 3'h0};
    endfunction

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // One classic cycle; holds until ack is sampled high
    task automatic xfer(input logic we, input logic [7:0] adr, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge clock);
        wb_cyc <= 1'h1;
        wb_stb <= 1'h1;
        wb_we <= we;
        wb_adr <= adr;
        wb_dat_wr <= wd;
        do begin
            @(posedge clock);
            n++;
        end while (wb_ack !== 1'h1 && n < 20);
        v = wb_dat_rd;
        wb_cyc <= 1'h0;
        wb_stb <= 1'h0;
        if (wb_ack !== 1'h1) begin
            error_cnt++;
            tally_and_finish();
        end
    endtask

    task automatic wr(input logic [7:0] adr, input logic [7:0] d);
        xfer(1'h1, adr, {24'h000000, d});
    endtask

    task automatic rd_chk(input string what, input logic [7:0] adr, input logic [7:0] exp);
        xfer(1'h0, adr, 32'h00000000);
        check(what, v, {24'h000000, exp});
    endtask

    task automatic fire_ev(input int k);
        fire <= 11'h001 << k;
        @(posedge clock);
        fire <= 11'h000;
    endtask

    // Interrupt outputs after they settle, masked fields only
    task automatic irq_chk(input string what, input logic [17:0] exp, input logic [17:0] msk);
        repeat (3) @(posedge clock);
        check(what, {14'h0000, {irq_request, irq_high, irq_vector} & msk}, {14'h0000, exp});
    endtask

    initial begin
        logic [31:0] r;
        logic [3:0] s;
        int c;
        repeat (5) @(posedge clock);
        rst <= 1'h0;
        // Values after reset
        rd_chk("ctl2 reset", R2, epir_pkg::RST_INT_CONTROL_TWO);
        rd_chk("ctl3 reset", R3, epir_pkg::RST_INT_CONTROL_THREE);
        rd_chk("req1 reset", Q1, 8'h00);
        rd_chk("req2 reset", Q2, 8'h00);
        check("pullups reset", {24'h000000, portb_pullup_on}, 32'h00000000);
        // Unmapped place and a write with lane 0 off
        wr(8'h40, 8'h5A);
        rd_chk("unmapped", 8'h40, 8'h00);
        wb_sel <= 4'hE;
        wr(R2, 8'h00);
        wb_sel <= 4'hF;
        rd_chk("lane off write", R2, 8'hFF);
        // Random pull-up and edge rounds
        repeat (4) begin
            r = xs();
            s = r[3:0];
            portb_latch <= r[15:8];
            wr(R2, ctl2_of(r[16], s));
            ext_pin <= s;
            repeat (8) @(posedge clock);
            check("pullups", {24'h000000, portb_pullup_on}, r[16] ? 0 : r[15:8]);
            wr(R3, 8'hC0);
            c = ev0_cnt;
            ext_pin <= ~s;
            repeat (8) @(posedge clock);
            rd_chk("inactive edge", R3, 8'hC0);
            ext_pin <= s;
            repeat (8) @(posedge clock);
            rd_chk("active edge", R3, 8'hC7);
            check("ext0 pulses", ev0_cnt - c, 32'h00000001);
            wr(R3, 8'hC0);
            rd_chk("ext cleared", R3, 8'hC0);
        end
        // Every peripheral event with all enables off
        for (int k = 0; k < 11; k++) begin
            fire_ev(k);
            rd_chk("event flag", ev_off(k), ev_mask(k));
            wr(ev_off(k), 8'h00);
            rd_chk("flag cleared", ev_off(k), 8'h00);
        end
        // Event arriving at the edge of a clearing write
        fork
            wr(Q1, 8'h00);
            fire_ev(1);
        join
        rd_chk("event beats clear", Q1, 8'h40);
        wr(Q1, 8'h00);
        // Capture/compare events in PWM mode
        pwm_mode <= 2'h3;
        fire_ev(3);
        @(posedge clock);
        fire_ev(10);
        rd_chk("pwm unit1", Q1, 8'h00);
        rd_chk("pwm unit2", Q2, 8'h00);
        pwm_mode <= 2'h0;
        // Software set and unimplemented bits
        wr(Q2, 8'hFF);
        rd_chk("req2 bits", Q2, epir_pkg::MASK_REQUEST_TWO);
        wr(Q2, 8'h00);
        // Buffer status bits ignore writes and follow inputs
        rx_full <= 1'h1;
        tx_empty <= 1'h1;
        wr(Q1, 8'h00);
        rd_chk("status held", Q1, 8'h30);
        rx_full <= 1'h0;
        rd_chk("rx follows", Q1, 8'h10);
        tx_empty <= 1'h0;
        rd_chk("tx follows", Q1, 8'h00);
        // External source, compatibility mode
        wr(R3, 8'h08);
        wr(R3, 8'h09);
        wr(CORE, 8'h80);
        irq_chk("irq compat", {2'h2, epir_pkg::VEC_HIGH}, 18'h2FFFF);
        // Priority feature on
        wr(CORE, 8'h81);
        irq_chk("low gated", 18'h00000, 18'h20000);
        wr(CORE, 8'hC1);
        irq_chk("irq low", {2'h2, epir_pkg::VEC_LOW}, 18'h3FFFF);
        wr(R3, 8'h49);
        irq_chk("irq high", {2'h3, epir_pkg::VEC_HIGH}, 18'h3FFFF);
        wr(R3, 8'h00);
        // Peripheral source needs the peripheral enable
        wr(CORE, 8'h80);
        wr(epir_pkg::OFF_PERIPH_EN_ONE, 8'h01);
        wr(Q1, 8'h01);
        irq_chk("periph gated", 18'h00000, 18'h20000);
        wr(CORE, 8'hC0);
        irq_chk("periph irq", {2'h2, epir_pkg::VEC_HIGH}, 18'h2FFFF);
        wr(Q1, 8'h00);
        // Timer 0 priority bit with only the high level enabled
        timer0_req <= 1'h1;
        wr(CORE, 8'h81);
        wr(R2, 8'hFC);
        irq_chk("timer0 high", {2'h3, epir_pkg::VEC_HIGH}, 18'h3FFFF);
        wr(R2, 8'hF8);
        irq_chk("timer0 low", 18'h00000, 18'h20000);
        timer0_req <= 1'h0;
        // Port change and ext3 priority bits
        port_chg_req <= 1'h1;
        wr(R2, 8'hF9);
        irq_chk("port chg high", {2'h3, epir_pkg::VEC_HIGH}, 18'h3FFFF);
        port_chg_req <= 1'h0;
        wr(R3, 8'h24);
        irq_chk("ext3 low", 18'h00000, 18'h20000);
        wr(R2, 8'hFA);
        irq_chk("ext3 high", {2'h3, epir_pkg::VEC_HIGH}, 18'h3FFFF);
        wr(R3, 8'h00);
        wr(CORE, 8'h00);
        tally_and_finish();
    end
endmodule

`default_nettype wire
